/* File: hdl/pmp_mgmt_port.sv */
// Operation
// - Bus runs only at 100 or 400 kHz
// - Command handling follows PMBus 1.3 transactions
// - Special options bit 7 makes PEC mandatory
// - Bus address is strap index plus base
// - Strap resistor decodes to index 0..13
// - Address 0, 11 or 12 becomes 127
// - Busy flag reported when request cannot be served
// - Alert line driven on any unmasked protection fault
// - Temperature readout follows selected sensor source
// - Defaults load from store, all settings rewritable; reset here loads settings and store alike from fixed values
// - Telemetry readouts answer at any time
// - Alert holds until clear or re-enable; maskable
`timescale 1ns/10ps
`include "pmp_params.svh"
module pmp_mgmt_port
  import pmp_pkg::*;
#(
  parameter int unsigned STORE_CYC = `PMP_STORE_CYC
) (
  // Core clock and control
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Link clock
  input  wire logic       link_clk,
  // Bus pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oen,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oen,
  output logic            alert_line_o,
  output logic            alert_line_oen,
  // Strap and converter side
  input  wire logic [3:0] address_strap_pin,
  input  wire logic [7:0] fault_in,
  input  wire logic       output_enable,
  input  wire pmp_tele_t  tele
);

  localparam logic [19:0] STORE_LOAD = STORE_CYC[19:0];

  // CRC-8 step for packet error code
  function automatic logic [7:0] pmp_crc8(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `PMP_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : pmp_crc8

  // Address from strap index and base, with reserved remap
  function automatic logic [6:0] pmp_bus_addr(input logic [3:0] idx, input logic [7:0] base);
    logic [7:0] s;
    s = base + {4'h0, idx};
    if (s == 8'h00 || s == 8'h0B || s == 8'h0C) begin
      return `PMP_ADDR_ALT;
    end
    return s[6:0];
  endfunction : pmp_bus_addr

  // Send-byte commands carry no data byte
  function automatic logic [1:0] pmp_need(input logic [7:0] cmd);
    if (cmd == `PMP_CMD_CLEAR || cmd == `PMP_CMD_STORE || cmd == `PMP_CMD_RESTORE) begin
      return 2'd1;
    end
    return 2'd2;
  endfunction : pmp_need

  pmp_link_t l, l_nxt;
  pmp_core_t c, c_nxt;
  logic [1:0] rsync_r;
  logic       lrst;

  localparam pmp_link_t L_RST = '{st: L_IDLE, scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
                                  sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
                                  scl_oen: 1'b1, sda_oen: 1'b1,
                                  evt: '{kind: EV_STOP, default: '0}, default: '0};
  localparam pmp_cfg_t  CFG_RST = '{tsrc: `PMP_TSRC_RST, spec: `PMP_SPEC_RST,
                                    abase: `PMP_ABASE_RST, mask: `PMP_MASK_RST};
  localparam pmp_core_t C_RST = '{cfg: CFG_RST, shadow: CFG_RST, alert_oen: 1'b1,
                                  rsp: '0, wbuf: '0, default: '0};

  // Reset carried into the link domain
  always_ff @(posedge link_clk) begin
    rsync_r <= {rsync_r[0], srst};
  end
  assign lrst = rsync_r[1];

  // Link side: bit engine with clock stretching
  always_comb begin
    logic rise, fall, start, stop, pend;
    l_nxt = l;
    l_nxt.scl_m = scl_i;
    l_nxt.scl_s = l.scl_m;
    l_nxt.scl_d = l.scl_s;
    l_nxt.sda_m = sda_i;
    l_nxt.sda_s = l.sda_m;
    l_nxt.sda_d = l.sda_s;
    l_nxt.ack_m = c.ack;
    l_nxt.ack_s = l.ack_m;
    rise  = l.scl_s & ~l.scl_d;
    fall  = ~l.scl_s & l.scl_d;
    start = l.scl_s & l.scl_d & l.sda_d & ~l.sda_s;
    stop  = l.scl_s & l.scl_d & ~l.sda_d & l.sda_s;
    pend  = l.req != l.ack_s;
    case (l.st)
      L_IDLE: begin
      end
      L_RX: begin
        if (rise) begin
          l_nxt.sh     = {l.sh[6:0], l.sda_s};
          l_nxt.bitcnt = l.bitcnt + 4'd1;
        end
        if (fall && l.bitcnt == 4'd8) begin
          l_nxt.scl_oen = 1'b0;
          l_nxt.issued  = 1'b0;
          l_nxt.st      = L_WAIT;
        end
      end
      L_WAIT: begin
        if (!l.issued && !pend) begin
          l_nxt.evt    = '{kind: EV_BYTE, first: l.first, data: l.sh};
          l_nxt.req    = ~l.req;
          l_nxt.issued = 1'b1;
        end else if (l.issued && !pend) begin
          l_nxt.sda_oen = ~c.rsp.ack;
          l_nxt.scl_oen = 1'b1;
          l_nxt.st      = L_ACK;
        end
      end
      L_ACK: begin
        if (fall) begin
          l_nxt.first   = 1'b0;
          l_nxt.sda_oen = 1'b1;
          l_nxt.bitcnt  = 4'd0;
          if (!c.rsp.ack) begin
            l_nxt.st = L_IDLE;
          end else if (c.rsp.tx) begin
            l_nxt.scl_oen = 1'b0;
            l_nxt.issued  = 1'b0;
            l_nxt.st      = L_TXW;
          end else begin
            l_nxt.st = L_RX;
          end
        end
      end
      L_TXW: begin
        if (!l.issued && !pend) begin
          l_nxt.evt    = '{kind: EV_TX, first: 1'b0, data: 8'h00};
          l_nxt.req    = ~l.req;
          l_nxt.issued = 1'b1;
        end else if (l.issued && !pend) begin
          l_nxt.sh      = c.rsp.data;
          l_nxt.sda_oen = c.rsp.data[7];
          l_nxt.scl_oen = 1'b1;
          l_nxt.bitcnt  = 4'd0;
          l_nxt.st      = L_TX;
        end
      end
      L_TX: begin
        if (fall) begin
          if (l.bitcnt == 4'd7) begin
            l_nxt.sda_oen = 1'b1;
            l_nxt.st      = L_RACK;
          end else begin
            l_nxt.bitcnt  = l.bitcnt + 4'd1;
            l_nxt.sh      = {l.sh[6:0], 1'b0};
            l_nxt.sda_oen = l.sh[6];
          end
        end
      end
      L_RACK: begin
        if (rise) begin
          l_nxt.mack = ~l.sda_s;
        end
        if (fall) begin
          if (l.mack) begin
            l_nxt.scl_oen = 1'b0;
            l_nxt.issued  = 1'b0;
            l_nxt.st      = L_TXW;
          end else begin
            l_nxt.st = L_IDLE;
          end
        end
      end
      L_STOP: begin
        if (!pend) begin
          l_nxt.evt = '{kind: EV_STOP, first: 1'b0, data: 8'h00};
          l_nxt.req = ~l.req;
          l_nxt.st  = L_IDLE;
        end
      end
      default: l_nxt.st = L_IDLE;
    endcase
    // Bus conditions override the byte engine outside handshakes
    if (l.st != L_WAIT && l.st != L_TXW && l.st != L_STOP) begin
      if (start) begin
        l_nxt.st      = L_RX;
        l_nxt.bitcnt  = 4'd0;
        l_nxt.first   = 1'b1;
        l_nxt.sda_oen = 1'b1;
      end else if (stop) begin
        l_nxt.st      = L_STOP;
        l_nxt.sda_oen = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      l <= L_RST;
    end else begin
      l <= l_nxt;
    end
  end

  // Core side: command decode, registers, status and alert
  always_comb begin
    logic        match, clr, ok;
    logic [1:0]  need;
    logic [7:0]  cmd, sb, tb;
    logic [15:0] rv;
    c_nxt       = c;
    match       = 1'b0;
    clr         = 1'b0;
    ok          = 1'b0;
    sb          = 8'h00;
    tb          = 8'hFF;
    rv          = 16'hFFFF;
    cmd         = c.wbuf[0];
    need        = pmp_need(cmd);
    c_nxt.req_m = l.req;
    c_nxt.req_s = c.req_m;
    c_nxt.strap_m = address_strap_pin;
    c_nxt.strap_s = c.strap_m;
    c_nxt.oe_d  = output_enable;
    // Index follows the synchronised strap, so the reset value of the sync flops never sticks
    c_nxt.strap_idx  = (c.strap_s > `PMP_STRAP_MAX) ? `PMP_STRAP_MAX : c.strap_s;
    c_nxt.strap_done = 1'b1;
    if (c.store_cnt != 20'h00000) begin
      c_nxt.store_cnt = c.store_cnt - 20'h00001;
    end
    // Status byte and readout word
    sb = 8'h00;
    sb[`PMP_BUSY_BIT]  = c.busy_seen | (c.store_cnt != 20'h00000);
    sb[`PMP_CML_BIT]   = |c.cml;
    sb[`PMP_OTHER_BIT] = |c.faults;
    case (cmd)
      `PMP_CMD_VIN:       rv = tele.vin;
      `PMP_CMD_VOUT:      rv = tele.vout;
      `PMP_CMD_IOUT:      rv = tele.iout;
      `PMP_CMD_TEMP:      rv = c.cfg.tsrc[`PMP_TSRC_EXT_BIT] ? tele.temp_ext : tele.temp_int;
      `PMP_CMD_FREQ:      rv = tele.freq;
      `PMP_CMD_DUTY:      rv = tele.duty;
      `PMP_CMD_STAT_BYTE: rv = {8'h00, sb};
      `PMP_CMD_STAT_CML:  rv = {8'h00, c.cml};
      `PMP_CMD_STAT_MFR:  rv = {8'h00, c.faults};
      `PMP_CMD_MASK:      rv = {8'h00, c.cfg.mask};
      `PMP_CMD_TSRC:      rv = {8'h00, c.cfg.tsrc};
      `PMP_CMD_SPEC:      rv = {8'h00, c.cfg.spec};
      `PMP_CMD_ABASE:     rv = {8'h00, c.cfg.abase};
      default:            rv = 16'hFFFF;
    endcase
    if (c.txi == 2'd0) begin
      tb = rv[7:0];
    end else if (c.txi == 2'd1 && cmd[7]) begin
      tb = rv[15:8];
    end else if (c.txi == (cmd[7] ? 2'd2 : 2'd1)) begin
      tb = c.crc;
    end else begin
      tb = 8'hFF;
    end
    // Serve one link event per handshake
    if (c.req_s != c.ack) begin
      c_nxt.ack = ~c.ack;
      case (l.evt.kind)
        EV_BYTE: begin
          if (l.evt.first) begin
            match     = l.evt.data[7:1] == pmp_bus_addr(c.strap_idx, c.cfg.abase);
            c_nxt.rsp = '{ack: match, tx: match & l.evt.data[0], data: 8'hFF};
            if (match) begin
              c_nxt.active = 1'b1;
              c_nxt.rd     = c.rd | l.evt.data[0];
              c_nxt.txi    = 2'd0;
              c_nxt.crc    = pmp_crc8(c.active ? c.crc : 8'h00, l.evt.data);
            end
          end else begin
            c_nxt.rsp = '{ack: 1'b1, tx: 1'b0, data: 8'hFF};
            if (c.active && c.cnt != 2'd3) begin
              c_nxt.wbuf[c.cnt] = l.evt.data;
              c_nxt.cnt         = c.cnt + 2'd1;
            end
            c_nxt.crc_prev = c.crc;
            c_nxt.crc      = pmp_crc8(c.crc, l.evt.data);
          end
        end
        EV_TX: begin
          c_nxt.rsp = '{ack: 1'b1, tx: 1'b1, data: tb};
          c_nxt.crc = pmp_crc8(c.crc, tb);
          if (c.txi != 2'd3) begin
            c_nxt.txi = c.txi + 2'd1;
          end
        end
        EV_STOP: begin
          if (c.active && !c.rd && c.cnt != 2'd0) begin
            ok = (c.cnt == need && !c.cfg.spec[`PMP_PEC_REQ_BIT]) ||
                 (c.cnt == need + 2'd1 && c.wbuf[c.cnt - 2'd1] == c.crc_prev);
            if (!ok) begin
              c_nxt.cml[`PMP_CML_PEC_BIT] = 1'b1;
            end else if (c.store_cnt != 20'h00000) begin
              c_nxt.busy_seen = 1'b1;
            end else begin
              case (cmd)
                `PMP_CMD_CLEAR:   clr = 1'b1;
                `PMP_CMD_STORE: begin
                  c_nxt.shadow    = c.cfg;
                  c_nxt.store_cnt = STORE_LOAD;
                end
                `PMP_CMD_RESTORE: c_nxt.cfg = c.shadow;
                `PMP_CMD_MASK:    c_nxt.cfg.mask = c.wbuf[1];
                `PMP_CMD_TSRC:    c_nxt.cfg.tsrc = c.wbuf[1];
                `PMP_CMD_SPEC:    c_nxt.cfg.spec = c.wbuf[1];
                `PMP_CMD_ABASE:   c_nxt.cfg.abase = c.wbuf[1];
                default:          c_nxt.cml[`PMP_CML_INV_BIT] = 1'b1;
              endcase
            end
          end
          c_nxt.active = 1'b0;
          c_nxt.rd     = 1'b0;
          c_nxt.cnt    = 2'd0;
          c_nxt.crc    = 8'h00;
        end
        default: ;
      endcase
    end
    // Sticky faults; a new fault wins over a clear in the same cycle
    if (clr) begin
      c_nxt.cml       = 8'h00;
      c_nxt.busy_seen = 1'b0;
    end
    if (clr || (output_enable && !c.oe_d)) begin
      c_nxt.faults = 8'h00;
    end
    c_nxt.faults    = c_nxt.faults | fault_in;
    c_nxt.alert_oen = ~|(c_nxt.faults & ~c_nxt.cfg.mask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      c <= C_RST;
    end else if (ce) begin
      c <= c_nxt;
    end
  end

  // Pins straight from flops
  assign scl_o          = l.drv0;
  assign scl_oen        = l.scl_oen;
  assign sda_o          = l.drv0;
  assign sda_oen        = l.sda_oen;
  assign alert_line_o   = c.drv0;
  assign alert_line_oen = c.alert_oen;

endmodule : pmp_mgmt_port

/* File: inc/pmp_params.svh */
`ifndef PMP_PARAMS_SVH
`define PMP_PARAMS_SVH
// Command codes
`define PMP_CMD_CLEAR     8'h03
`define PMP_CMD_STORE     8'h15
`define PMP_CMD_RESTORE   8'h16
`define PMP_CMD_MASK      8'h1B
`define PMP_CMD_STAT_BYTE 8'h78
`define PMP_CMD_STAT_CML  8'h7E
`define PMP_CMD_STAT_MFR  8'h80
`define PMP_CMD_VIN       8'h88
`define PMP_CMD_VOUT      8'h8B
`define PMP_CMD_IOUT      8'h8C
`define PMP_CMD_TEMP      8'h8D
`define PMP_CMD_DUTY      8'h94
`define PMP_CMD_FREQ      8'h95
`define PMP_CMD_TSRC      8'hDC
`define PMP_CMD_SPEC      8'hE0
`define PMP_CMD_ABASE     8'hEE
// Field positions
`define PMP_PEC_REQ_BIT   7
`define PMP_TSRC_EXT_BIT  0
`define PMP_BUSY_BIT      7
`define PMP_CML_BIT       1
`define PMP_OTHER_BIT     0
`define PMP_CML_INV_BIT   7
`define PMP_CML_PEC_BIT   5
// Reset values
`define PMP_TSRC_RST      8'h00
`define PMP_SPEC_RST      8'h00
`define PMP_ABASE_RST     8'h60
`define PMP_MASK_RST      8'h00
// Address decode and CRC polynomial
`define PMP_STRAP_MAX     4'hD
`define PMP_ADDR_ALT      7'h7F
`define PMP_CRC_POLY      8'h07
// Timing
`define PMP_CLK_MHZ       200
`define PMP_STORE_MS      5
`define PMP_STORE_CYC     (`PMP_STORE_MS * `PMP_CLK_MHZ * 1000)
`endif

/* File: inc/pmp_pkg.sv */
package pmp_pkg;
  typedef enum logic [7:0] {
    L_IDLE = 8'h01, L_RX = 8'h02, L_WAIT = 8'h04, L_ACK = 8'h08,
    L_TXW  = 8'h10, L_TX = 8'h20, L_RACK = 8'h40, L_STOP = 8'h80
  } pmp_lstate_t;
  typedef enum logic [2:0] {EV_BYTE = 3'h1, EV_TX = 3'h2, EV_STOP = 3'h4} pmp_evkind_t;
  typedef struct packed {
    pmp_evkind_t kind;
    logic        first;
    logic [7:0]  data;
  } pmp_evt_t;
  typedef struct packed {
    logic       ack;
    logic       tx;
    logic [7:0] data;
  } pmp_rsp_t;
  typedef struct packed {
    logic [7:0] tsrc;
    logic [7:0] spec;
    logic [7:0] abase;
    logic [7:0] mask;
  } pmp_cfg_t;
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp_int;
    logic [15:0] temp_ext;
    logic [15:0] freq;
    logic [15:0] duty;
  } pmp_tele_t;
  typedef struct packed {
    logic        scl_m, scl_s, scl_d;
    logic        sda_m, sda_s, sda_d;
    pmp_lstate_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  sh;
    logic        first, issued, mack;
    logic        req, ack_m, ack_s;
    pmp_evt_t    evt;
    logic        scl_oen, sda_oen, drv0;
  } pmp_link_t;
  typedef struct packed {
    logic            req_m, req_s, ack;
    pmp_rsp_t        rsp;
    logic [3:0]      strap_m, strap_s, strap_idx;
    logic            strap_done;
    logic            active, rd;
    logic [1:0]      cnt, txi;
    logic [2:0][7:0] wbuf;
    logic [7:0]      crc, crc_prev;
    pmp_cfg_t        cfg, shadow;
    logic [19:0]     store_cnt;
    logic [7:0]      faults, cml;
    logic            busy_seen, oe_d, alert_oen, drv0;
  } pmp_core_t;
endpackage : pmp_pkg

/* File: sim/pmp_host_model.sv */
`timescale 1ns/10ps
module pmp_host_model #(
  parameter int QTR_NS = 625
) (
  // Resolved wire levels
  scl,
  sda,
  // Pull-low drives
  scl_low,
  sda_low
);
  input  wire logic scl;
  input  wire logic sda;
  output logic      scl_low;
  output logic      sda_low;
  // Lines released at power-up
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // One 400 kHz bit, waiting out any stretch
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #QTR_NS;
    scl_low = 1'b0;
    wait (scl === 1'b1);
    #QTR_NS;
    s = sda;
    #QTR_NS;
    scl_low = 1'b1;
    #QTR_NS;
  endtask : bit_io
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    #QTR_NS;
    scl_low = 1'b0;
    wait (scl === 1'b1);
    #QTR_NS;
    sda_low = 1'b1;
    #QTR_NS;
    scl_low = 1'b1;
    #QTR_NS;
  endtask : start
  // Stop, then bus-free time
  task automatic stop();
    sda_low = 1'b1;
    #QTR_NS;
    scl_low = 1'b0;
    wait (scl === 1'b1);
    #QTR_NS;
    sda_low = 1'b0;
    #(QTR_NS * 8);
  endtask : stop
  // Byte out and in, ninth bit given and sampled
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
                      output logic s9);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s9);
      r[i] = s9;
    end
    bit_io(b9, s9);
  endtask : xfer
endmodule : pmp_host_model

/* File: sim/pmp_mgmt_port_checker.sv */
`timescale 1ns/10ps
module pmp_mgmt_port_checker
  import pmp_pkg::*;
(
  // Clocks and control
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       link_clk,
  // Bus and alert pins
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oen,
  input wire logic       sda_o,
  input wire logic       sda_oen,
  input wire logic       alert_line_o,
  input wire logic       alert_line_oen,
  // Converter side
  input wire logic [7:0] fault_in,
  input wire logic       output_enable
);
  // Link pins released while reset has reached the link domain
  chk_idle_reset: assert property (@(posedge link_clk) srst [*5] |-> scl_oen && sda_oen)
    else $error("bus pins driven during reset");
  // Alert released while reset is held
  chk_alert_reset: assert property (@(posedge clk) srst [*2] |-> alert_line_oen)
    else $error("alert active during reset");
  // Open-drain pins only ever pull low
  chk_pins_low: assert property (@(posedge clk) disable iff (srst)
    !scl_o && !sda_o && !alert_line_o)
    else $error("open-drain level not low");
  // Clock stretch ends within a bounded time while the core runs
  chk_stretch_bound: assert property (@(posedge link_clk) disable iff (srst || !ce)
    $fell(scl_oen) |-> ##[1:60] scl_oen)
    else $error("clock stretch too long");
  // Data line never moves while SCL stays high
  chk_sda_steady: assert property (@(posedge link_clk) disable iff (srst)
    scl_i [*3] |-> $stable(sda_oen))
    else $error("data changed while clock high");
  // Unmasked fault pulls the alert low promptly
  chk_fault_alert: assert property (@(posedge clk) disable iff (srst)
    ce && (|fault_in) |-> ##[1:3] !alert_line_oen)
    else $error("fault did not raise alert");
  // Alert only falls after a fault
  chk_alert_cause: assert property (@(posedge clk) disable iff (srst)
    $fell(alert_line_oen) |-> $past(|fault_in) || $past(|fault_in, 2))
    else $error("alert without fault");
  // Frozen core keeps the alert steady
  chk_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce [*3] |-> $stable(alert_line_oen))
    else $error("alert moved while core frozen");
endmodule : pmp_mgmt_port_checker

/* File: sim/pmp_mgmt_port_tb.sv */
`timescale 1ns/10ps
module pmp_mgmt_port_tb
  import pmp_pkg::*;
;
  // Design inputs and outputs
  logic         clk, link_clk, srst, ce, output_enable;
  logic [3:0]   address_strap_pin;
  logic [7:0]   fault_in;
  pmp_tele_t    tele;
  logic         scl_o, scl_oen, sda_o, sda_oen, alert_line_o, alert_line_oen;
  logic         scl_low, sda_low;
  wire logic    scl, sda;
  int           n_fail, check_count, seed;
  logic [6:0]   dev_addr;
  logic         ak;
  logic [15:0]  w;
  logic [127:0] rnd;
  // Pull-up wires seen by both ends
  assign scl = !(scl_low || !scl_oen);
  assign sda = !(sda_low || !sda_oen);
  // Core clock, 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Link clock, 15 ns, own phase
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  pmp_mgmt_port #(.STORE_CYC(50)) pmp_mgmt_port_inst (
    .clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk),
    .scl_i(scl), .scl_o(scl_o), .scl_oen(scl_oen),
    .sda_i(sda), .sda_o(sda_o), .sda_oen(sda_oen),
    .alert_line_o(alert_line_o), .alert_line_oen(alert_line_oen),
    .address_strap_pin(address_strap_pin), .fault_in(fault_in),
    .output_enable(output_enable), .tele(tele));
  pmp_host_model pmp_host_model_inst (
    .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  // Expected bus address from strap index and base
  function automatic logic [6:0] addr_of(input logic [3:0] idx, input logic [7:0] base);
    logic [7:0] s;
    s = {4'h0, idx} + base;
    if (s == 8'h00 || s == 8'h0B || s == 8'h0C) return 7'h7F;
    return s[6:0];
  endfunction : addr_of
  // Packet error code step, CRC-8 with polynomial 0x07
  function automatic logic [7:0] pec8(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] x;
    x = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction : pec8
  // Compare tasks
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word
  // Write byte transfer, returns address ack
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    output logic ack);
    logic [7:0] r;
    logic       s;
    pmp_host_model_inst.start();
    pmp_host_model_inst.xfer({a, 1'b0}, 1'b1, r, s);
    ack = !s;
    if (ack) begin
      pmp_host_model_inst.xfer(c, 1'b1, r, s);
      pmp_host_model_inst.xfer(d, 1'b1, r, s);
    end
    pmp_host_model_inst.stop();
  endtask : wr
  // Write byte transfer with packet error code appended
  task automatic wr_pec(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                        output logic ack);
    logic [7:0] r;
    logic       s;
    pmp_host_model_inst.start();
    pmp_host_model_inst.xfer({a, 1'b0}, 1'b1, r, s);
    ack = !s;
    pmp_host_model_inst.xfer(c, 1'b1, r, s);
    pmp_host_model_inst.xfer(d, 1'b1, r, s);
    pmp_host_model_inst.xfer(pec8(pec8(pec8(8'h00, {a, 1'b0}), c), d), 1'b1, r, s);
    pmp_host_model_inst.stop();
  endtask : wr_pec
  // Read word transfer, low byte first
  task automatic rd_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d);
    logic [7:0] r;
    logic       s;
    pmp_host_model_inst.start();
    pmp_host_model_inst.xfer({a, 1'b0}, 1'b1, r, s);
    pmp_host_model_inst.xfer(c, 1'b1, r, s);
    pmp_host_model_inst.start();
    pmp_host_model_inst.xfer({a, 1'b1}, 1'b1, r, s);
    pmp_host_model_inst.xfer(8'hFF, 1'b0, d[7:0], s);
    pmp_host_model_inst.xfer(8'hFF, 1'b1, d[15:8], s);
    pmp_host_model_inst.stop();
  endtask : rd_word
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    seed = 92744;
    n_fail = 0;
    check_count = 0;
    srst = 1'b1;
    ce = 1'b1;
    output_enable = 1'b1;
    fault_in = 8'h00;
    address_strap_pin = 4'($unsigned($random(seed)) % 14);
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
    tele = rnd[111:0];
    dev_addr = addr_of(address_strap_pin, 8'h60);
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (20) @(negedge clk);
    ce = 1'b0;
    repeat (10) @(negedge clk);
    ce = 1'b1;
    repeat (10) @(negedge clk);
    wr(dev_addr + 7'h01, 8'hDC, 8'h01, ak);
    chk_bit(ak, 1'b0, "stray address acked");
    wr(dev_addr, 8'hDC, 8'h01, ak);
    chk_bit(ak, 1'b1, "own address refused");
    wr(dev_addr, 8'hE0, 8'h80, ak);
    wr(dev_addr, 8'hDC, 8'h00, ak);
    rd_word(dev_addr, 8'h8D, w);
    chk_word(w, tele.temp_ext, "temperature readout");
    wr_pec(dev_addr, 8'hDC, 8'h00, ak);
    chk_bit(ak, 1'b1, "PEC write refused");
    rd_word(dev_addr, 8'h8D, w);
    chk_word(w, tele.temp_int, "internal temperature");
    @(negedge clk);
    fault_in = 8'h01 << ($unsigned($random(seed)) % 8);
    @(negedge clk);
    fault_in = 8'h00;
    repeat (4) @(negedge clk);
    chk_bit(alert_line_oen, 1'b0, "alert on fault");
    repeat (20) @(negedge clk);
    chk_bit(alert_line_oen, 1'b0, "alert held");
    output_enable = 1'b0;
    repeat (2) @(negedge clk);
    output_enable = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(alert_line_oen, 1'b1, "alert after re-enable");
    finish_test();
  end
  // Hang guard
  initial begin
    #750_000;
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end
endmodule : pmp_mgmt_port_tb

bind pmp_mgmt_port pmp_mgmt_port_checker pmp_mgmt_port_checker_inst (
  .clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oen(scl_oen), .sda_o(sda_o), .sda_oen(sda_oen), .alert_line_o(alert_line_o),
  .alert_line_oen(alert_line_oen), .fault_in(fault_in), .output_enable(output_enable));
